// >>> verilog/dcwl_map.svh
// Register offsets, field positions, device codes and reset values of the word link
`ifndef DCWL_MAP_SVH
`define DCWL_MAP_SVH

`define DCWL_OFF_CMD 8'h00
`define DCWL_OFF_ACC 8'h04
`define DCWL_OFF_RESULT 8'h08
`define DCWL_OFF_STATUS 8'h0C
`define DCWL_OFF_MASK 8'h10

`define DCWL_CMD_DEV_LSB 0
`define DCWL_CMD_DEV_MSB 5
`define DCWL_CMD_XFER_LSB 6
`define DCWL_CMD_XFER_MSB 7
`define DCWL_CMD_FUNC_LSB 8
`define DCWL_CMD_FUNC_MSB 9

`define DCWL_DEV_RX 6'h20
`define DCWL_DEV_TX 6'h21
`define DCWL_DEV_ILK 6'h1E

`define DCWL_MASK_FD_BIT 0
`define DCWL_MASK_ILK_BIT 6
`define DCWL_MASK_RESET 7'h00

`define DCWL_ST_RX_BUSY 0
`define DCWL_ST_RX_DONE 1
`define DCWL_ST_TX_BUSY 2
`define DCWL_ST_TX_DONE 3
`define DCWL_ST_ILK_BUSY 4
`define DCWL_ST_ILK_DONE 5
`define DCWL_ST_PRIMARY 6

`define DCWL_WORD_RESET 16'h0000

`endif

// >>> verilog/dcwl_pkg.sv
// Types shared by the word link design
package dcwl_pkg;

	typedef enum logic [1:0]
	{
		XFER_NONE,
		XFER_READ,
		XFER_WRITE,
		XFER_CLEAR_FLAGS
	} dcwl_xfer_t;

	typedef enum logic [1:0]
	{
		FUNC_NONE,
		FUNC_START,
		FUNC_CLEAR,
		FUNC_PULSE
	} dcwl_func_t;

	// Everything carried by the cable in one direction; t_* are toggle events
	typedef struct packed
	{
		logic [15:0] fd_word;
		logic [15:0] hd_word;
		logic rx_busy;
		logic tx_busy;
		logic ilk_busy;
		logic t_release;
		logic t_tx_start;
		logic t_fd_word;
		logic t_ilk_free;
		logic t_ilk_notify;
		logic t_hd_word;
	} dcwl_link_t;

endpackage

// >>> verilog/dcwl_pin_sync.sv
// Three-stage synchroniser with agreement filter for the cable inputs
`timescale 1ns/100ps
module dcwl_pin_sync
#(
	parameter int WIDTH = 41
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] stable
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// A bit is taken only once the second and third stages agree
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			stable <= '0;
		end
		else
		begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (stage2[i] == stage3[i])
					stable[i] <= stage3[i];
			end
		end
	end
endmodule

// >>> verilog/dcwl_link_core.sv
// One side of the dual processor word link: full duplex ports, shared interlock port, APB registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "dcwl_map.svh"
module dcwl_link_core
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_primary,
	input wire dcwl_pkg::dcwl_link_t link_in,
	output dcwl_pkg::dcwl_link_t link_out,
	output logic irq
);
	import dcwl_pkg::*;

	localparam int LINK_W = $bits(dcwl_link_t);

	logic [LINK_W-1:0] peer_bits;
	dcwl_link_t peer;
	dcwl_link_t peer_prev;
	logic [15:0] acc;
	logic [15:0] result;
	logic [15:0] rx_buf;
	logic [15:0] hd_buf;
	logic [6:0] mask;
	logic rx_busy;
	logic rx_done;
	logic tx_busy;
	logic tx_done;
	logic ilk_busy;
	logic ilk_done;
	logic primary;
	logic strap_taken;
	logic [31:0] rd_val;
	logic addr_ok;

	////////////////////////////////////////////////////////////////////////////
	// Cable inputs

	dcwl_pin_sync #(.WIDTH(LINK_W)) u_sync
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(link_in),
		.stable(peer_bits)
	);

	assign peer = dcwl_link_t'(peer_bits);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			peer_prev <= '0;
		else
			peer_prev <= peer;
	end

	wire ev_release = peer.t_release ^ peer_prev.t_release;
	wire ev_tx_start = peer.t_tx_start ^ peer_prev.t_tx_start;
	wire ev_fd_word = peer.t_fd_word ^ peer_prev.t_fd_word;
	wire ev_ilk_free = peer.t_ilk_free ^ peer_prev.t_ilk_free;
	wire ev_ilk_notify = peer.t_ilk_notify ^ peer_prev.t_ilk_notify;
	wire ev_hd_word = peer.t_hd_word ^ peer_prev.t_hd_word;

	// Strap is caught once after reset release, never under the reset itself
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			primary <= 1'b0;
			strap_taken <= 1'b0;
		end
		else if (!strap_taken)
		begin
			primary <= link_primary;
			strap_taken <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decode; a command acts at the edge that completes its APB write

	wire bus_done = psel & penable & pready;
	wire cmd_go = bus_done & pwrite & (paddr == `DCWL_OFF_CMD);
	wire dcwl_xfer_t xfer = dcwl_xfer_t'(pwdata[`DCWL_CMD_XFER_MSB:`DCWL_CMD_XFER_LSB]);
	wire dcwl_func_t func = dcwl_func_t'(pwdata[`DCWL_CMD_FUNC_MSB:`DCWL_CMD_FUNC_LSB]);

	function automatic logic dev_hit(input logic go, input logic [31:0] cmd, input logic [5:0] code);
		return go && (cmd[`DCWL_CMD_DEV_MSB:`DCWL_CMD_DEV_LSB] == code);
	endfunction

	wire rx_cmd = dev_hit(cmd_go, pwdata, `DCWL_DEV_RX);
	wire tx_cmd = dev_hit(cmd_go, pwdata, `DCWL_DEV_TX);
	wire ilk_cmd = dev_hit(cmd_go, pwdata, `DCWL_DEV_ILK);
	wire ilk_dib = ilk_cmd && (xfer == XFER_CLEAR_FLAGS);
	// Clear-flags ignores any coded function, whose result is undefined anyway
	wire ilk_fn = ilk_cmd && !ilk_dib;

	wire rx_read = rx_cmd && (xfer == XFER_READ);
	wire rx_start = rx_cmd && (func == FUNC_START);
	wire rx_clear = rx_cmd && (func == FUNC_CLEAR);
	wire tx_write = tx_cmd && (xfer == XFER_WRITE);
	wire tx_start = tx_cmd && (func == FUNC_START);
	wire tx_clear = tx_cmd && (func == FUNC_CLEAR);
	wire ilk_read = ilk_fn && (xfer == XFER_READ);
	wire ilk_write = ilk_fn && (xfer == XFER_WRITE);
	wire ilk_start = ilk_fn && (func == FUNC_START);
	wire ilk_clear = ilk_fn && (func == FUNC_CLEAR);
	wire ilk_pulse = ilk_fn && (func == FUNC_PULSE);
	wire rel_out = (rx_start && rx_busy) || rx_clear;

	////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state so that read data comes from a flip-flop

	always_comb
	begin
		addr_ok = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			`DCWL_OFF_CMD: rd_val = 32'h0000_0000;
			`DCWL_OFF_ACC: rd_val = {16'h0000, acc};
			`DCWL_OFF_RESULT: rd_val = {16'h0000, result};
			`DCWL_OFF_STATUS:
			begin
				rd_val[`DCWL_ST_RX_BUSY] = rx_busy;
				rd_val[`DCWL_ST_RX_DONE] = rx_done;
				rd_val[`DCWL_ST_TX_BUSY] = tx_busy;
				rd_val[`DCWL_ST_TX_DONE] = tx_done;
				rd_val[`DCWL_ST_ILK_BUSY] = ilk_busy;
				rd_val[`DCWL_ST_ILK_DONE] = ilk_done;
				rd_val[`DCWL_ST_PRIMARY] = primary;
			end
			`DCWL_OFF_MASK: rd_val = {25'h0000000, mask};
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr <= ~addr_ok;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc <= `DCWL_WORD_RESET;
			mask <= `DCWL_MASK_RESET;
		end
		else if (bus_done & pwrite)
		begin
			if (paddr == `DCWL_OFF_ACC)
				acc <= pwdata[15:0];
			if (paddr == `DCWL_OFF_MASK)
				mask <= pwdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Full duplex receive flags

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_busy <= 1'b0;
			rx_done <= 1'b0;
		end
		else
		begin
			if (rx_start)
			begin
				rx_busy <= 1'b1;
				rx_done <= peer.tx_busy;
			end
			else if (rx_clear)
			begin
				rx_busy <= 1'b0;
				rx_done <= 1'b0;
			end
			// A peer start arriving with the local command still sets done
			if (ev_tx_start && (rx_busy || rx_start))
				rx_done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Full duplex transmit flags

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_busy <= 1'b0;
			tx_done <= 1'b0;
		end
		else
		begin
			if (tx_start)
			begin
				tx_busy <= 1'b1;
				tx_done <= 1'b0;
			end
			else if (tx_clear)
			begin
				tx_busy <= 1'b0;
				tx_done <= 1'b0;
			end
			if (ev_release)
			begin
				tx_busy <= 1'b0;
				tx_done <= tx_busy;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interlock flags

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ilk_busy <= 1'b0;
			ilk_done <= 1'b0;
		end
		else
		begin
			if (ilk_start && !peer.ilk_busy)
				ilk_busy <= 1'b1;
			if (ilk_clear || ilk_pulse)
				ilk_done <= 1'b0;
			if (ilk_dib)
			begin
				ilk_busy <= 1'b0;
				ilk_done <= 1'b0;
			end
			if (ev_ilk_free)
				ilk_busy <= 1'b0;
			// Both claimed inside the cable latency: the secondary side backs off
			if (ilk_busy && peer.ilk_busy && !primary)
				ilk_busy <= 1'b0;
			if (ev_ilk_notify)
				ilk_done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word buffers and read results

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_buf <= `DCWL_WORD_RESET;
			hd_buf <= `DCWL_WORD_RESET;
			result <= `DCWL_WORD_RESET;
		end
		else
		begin
			if (ev_fd_word)
				rx_buf <= peer.fd_word;
			// Each side keeps a copy of the shared word; a local write wins a collision
			if (ilk_write)
				hd_buf <= acc;
			else if (ev_hd_word)
				hd_buf <= peer.hd_word;
			if (rx_read)
				result <= rx_buf;
			else if (ilk_read)
				result <= hd_buf;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cable outputs; word and its toggle leave in the same cycle

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			link_out <= '0;
		else
		begin
			link_out.rx_busy <= rx_busy;
			link_out.tx_busy <= tx_busy;
			link_out.ilk_busy <= ilk_busy;
			if (tx_write)
			begin
				link_out.fd_word <= acc;
				link_out.t_fd_word <= ~link_out.t_fd_word;
			end
			if (ilk_write)
			begin
				link_out.hd_word <= acc;
				link_out.t_hd_word <= ~link_out.t_hd_word;
			end
			if (rel_out)
				link_out.t_release <= ~link_out.t_release;
			if (tx_start)
				link_out.t_tx_start <= ~link_out.t_tx_start;
			if (ilk_clear)
				link_out.t_ilk_free <= ~link_out.t_ilk_free;
			if (ilk_pulse)
				link_out.t_ilk_notify <= ~link_out.t_ilk_notify;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= (~mask[`DCWL_MASK_FD_BIT] & (rx_done | tx_done)) | (~mask[`DCWL_MASK_ILK_BIT] & ilk_done);
	end
endmodule

// >>> testbench/dcwl_link_core_props.sv
// Port checker for the word link core
`timescale 1ns/100ps
module dcwl_link_core_props
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire dcwl_pkg::dcwl_link_t link_out,
	input wire logic irq
);
	import dcwl_pkg::*;
	logic c;
	logic [7:0] k;
	// Command word completing now; k packs function and device code
	assign c = psel && penable && pready && pwrite && paddr == 8'h00;
	assign k = {pwdata[9:8], pwdata[5:0]};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_ONE_WAIT:
		assert property (psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("late answer");
	AST_PULSE:
		assert property (pready |=> !pready) else $error("long answer");
	AST_RESET:
		assert property ($rose(rst_b) |-> link_out == '0 && !irq) else $error("not clear");
	AST_RX_START:
		assert property (c && k == 8'h60 |-> ##[1:3] link_out.rx_busy) else $error("rx busy");
	AST_RX_CLEAR:
		assert property (c && k == 8'hA0 |-> ##[1:3] $changed(link_out.t_release)) else $error("release");
	AST_TX_START:
		assert property (c && k == 8'h61 |-> ##[1:3] link_out.tx_busy) else $error("tx busy");
	AST_ILK_FREE:
		assert property (c && k == 8'h9E |-> ##[1:3] $changed(link_out.t_ilk_free)) else $error("free");
	AST_ILK_NOTIFY:
		assert property (c && k == 8'hDE |-> ##[1:3] $changed(link_out.t_ilk_notify)) else $error("notify");
	AST_UNLOCK:
		assert property (c && pwdata[7:0] == 8'hDE |-> ##[1:3] !link_out.ilk_busy) else $error("unlock");
endmodule
bind dcwl_link_core dcwl_link_core_props chk (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .link_out, .irq);

// >>> testbench/dcwl_peer_model.sv
// Behavioural far-side board: a secondary peer
`timescale 1ns/100ps
module dcwl_peer_model
(
	input wire logic core_clk,
	input wire dcwl_pkg::dcwl_link_t from_dut,
	output dcwl_pkg::dcwl_link_t to_dut
);
	import dcwl_pkg::*;
	dcwl_link_t prev;
	initial to_dut = '0;
	always @(posedge core_clk)
	begin
		prev <= from_dut;
		if (prev.t_release !== from_dut.t_release)
			to_dut.tx_busy <= 1'h0;
		if (prev.t_ilk_free !== from_dut.t_ilk_free)
			to_dut.ilk_busy <= 1'h0;
		// Secondary side gives way when both hold the lock
		if (to_dut.ilk_busy && from_dut.ilk_busy)
			to_dut.ilk_busy <= 1'h0;
	end
	task automatic fd_send(input logic [15:0] w);
		to_dut.fd_word <= w;
		to_dut.tx_busy <= 1'h1;
		to_dut.t_fd_word <= ~to_dut.t_fd_word;
		to_dut.t_tx_start <= ~to_dut.t_tx_start;
	endtask
	task automatic rx_clear;
		to_dut.t_release <= ~to_dut.t_release;
	endtask
	task automatic ilk_start;
		if (!from_dut.ilk_busy)
			to_dut.ilk_busy <= 1'h1;
	endtask
	task automatic hd_send(input logic [15:0] w);
		to_dut.hd_word <= w;
		to_dut.t_hd_word <= ~to_dut.t_hd_word;
		to_dut.t_ilk_notify <= ~to_dut.t_ilk_notify;
	endtask
endmodule

// >>> testbench/dual_cpu_word_link_interlock_tb.sv
// Self-checking bench for the word link core
`timescale 1ns/100ps
`define CHK(n, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			n_errors++; \
			$display("[FAIL] %s exp %h got %h", n, e, g); \
		end \
	end
module dual_cpu_word_link_interlock_tb;
	import dcwl_pkg::*;
	logic core_clk = 1'h0;
	logic rst_b = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] rd;
	logic err;
	dcwl_link_t to_dut;
	dcwl_link_t from_dut;
	int n_errors = 0;
	int total_checks = 0;
	always #4 core_clk = ~core_clk;
	dcwl_link_core dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_primary(1'h1), .link_in(to_dut), .link_out(from_dut), .irq(irq));
	dcwl_peer_model peer (.core_clk(core_clk), .from_dut(from_dut), .to_dut(to_dut));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		logic ok;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		i = 0;
		// Answer is looked at mid-cycle, so the edge that launches it cannot race the check
		do
		begin
			@(negedge core_clk);
			ok = pready;
			rd = prdata;
			err = pslverr;
			@(posedge core_clk);
			i++;
		end
		while (ok !== 1'h1 && i < 20);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge core_clk);
		if (i >= 20)
		begin
			n_errors++;
			stop_test();
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK("register", e, rd)
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		wt(10);
		rst_b <= 1'h1;
		wt(2);
		rdchk(8'h0C, 32'h40);
		rdchk(8'h10, 32'h0);
		apb(1'h0, 8'h20, 32'h0);
		`CHK("slverr", 1'h1, err)
		$display("reset test ended");
		apb(1'h1, 8'h00, 32'h120);
		wt(10);
		rdchk(8'h0C, 32'h41);
		peer.fd_send(16'hA5C3);
		wt(10);
		rdchk(8'h0C, 32'h43);
		`CHK("irq", 1'h1, irq)
		apb(1'h1, 8'h00, 32'h260);
		rdchk(8'h08, 32'hA5C3);
		apb(1'h1, 8'h00, 32'h060);
		rdchk(8'h08, 32'hA5C3);
		wt(10);
		rdchk(8'h0C, 32'h40);
		`CHK("peer tx busy", 1'h0, to_dut.tx_busy)
		peer.fd_send(16'h3C5A);
		wt(10);
		apb(1'h1, 8'h00, 32'h120);
		rdchk(8'h0C, 32'h43);
		apb(1'h1, 8'h00, 32'h160);
		rdchk(8'h08, 32'h3C5A);
		wt(10);
		`CHK("peer rearm", 1'h0, to_dut.tx_busy)
		apb(1'h1, 8'h00, 32'h220);
		$display("receive test ended");
		apb(1'h1, 8'h04, 32'h1234);
		apb(1'h1, 8'h00, 32'h1A1);
		wt(3);
		`CHK("tx word", 16'h1234, from_dut.fd_word)
		rdchk(8'h04, 32'h1234);
		rdchk(8'h0C, 32'h44);
		peer.rx_clear();
		wt(10);
		rdchk(8'h0C, 32'h48);
		apb(1'h1, 8'h00, 32'h221);
		rdchk(8'h0C, 32'h40);
		$display("transmit test ended");
		apb(1'h1, 8'h00, 32'h11E);
		wt(10);
		rdchk(8'h0C, 32'h50);
		peer.ilk_start();
		apb(1'h1, 8'h04, 32'hBEEF);
		apb(1'h1, 8'h00, 32'h39E);
		wt(3);
		`CHK("hd word", 16'hBEEF, from_dut.hd_word)
		`CHK("peer lock", 1'h0, to_dut.ilk_busy)
		peer.hd_send(16'h0F0F);
		wt(10);
		rdchk(8'h0C, 32'h70);
		apb(1'h1, 8'h10, 32'h40);
		wt(2);
		`CHK("irq masked", 1'h0, irq)
		apb(1'h1, 8'h00, 32'h35E);
		rdchk(8'h08, 32'h0F0F);
		apb(1'h1, 8'h00, 32'h0DE);
		rdchk(8'h0C, 32'h40);
		peer.ilk_start();
		wt(10);
		apb(1'h1, 8'h00, 32'h11E);
		wt(10);
		rdchk(8'h0C, 32'h40);
		apb(1'h1, 8'h00, 32'h21E);
		wt(10);
		`CHK("peer freed", 1'h0, to_dut.ilk_busy)
		peer.ilk_start();
		apb(1'h1, 8'h00, 32'h11E);
		wt(12);
		rdchk(8'h0C, 32'h50);
		`CHK("peer lost", 1'h0, to_dut.ilk_busy)
		$display("interlock test ended");
		stop_test();
	end
endmodule
